// ---- hdl/cbd_cfg.svh ----
// Opcode patterns, addresses and reset values for the instruction decoder
`ifndef CBD_CFG_SVH
`define CBD_CFG_SVH
// Top nibbles of bit-oriented, control, relative and extension words
`define OPN_BIT_CLR   4'h9
`define OPN_BIT_SET   4'h8
`define OPN_SKIP_CLR  4'hB
`define OPN_SKIP_SET  4'hA
`define OPN_BIT_TGL   4'h7
`define OPN_CTRL      4'hE
`define OPN_REL       4'hD
`define OPN_EXT       4'hF
// Top bytes of literal and long control words; call, bank select and pointer pad fields
`define OPB_LIT_ADD   8'h0F
`define OPB_LIT_AND   8'h0B
`define OPB_LIT_OR    8'h09
`define OPB_LIT_XOR   8'h0A
`define OPB_LIT_SUB   8'h08
`define OPB_LIT_MUL   8'h0D
`define OPB_LIT_MOV   8'h0E
`define OPB_LIT_RET   8'h0C
`define OPB_ABSOLUTE_JUMP_OP      8'hEF
`define OPB_POINTER_LOAD_OP      8'hEE
`define OPB_POINTER_LOAD_OP_W2   8'hF0
`define OP7_CALL      7'h76
`define OP12_BANK_SELECT_LOAD_OP    12'h010
`define POINTER_LOAD_OP_PAD      2'h0
// Whole-word controls, then 15- and 13-bit return and table prefixes
`define WORD_SLEEP    16'h0003
`define WORD_WATCHDOG_CLEAR_OP   16'h0004
`define WORD_PUSH     16'h0005
`define WORD_POP      16'h0006
`define WORD_RESET    16'h00FF
`define OP15_INTERRUPT_RETURN_OP   15'h0008
`define OP15_RETURN   15'h0009
`define OP13_TABLE    13'h0001
// Branch condition flag selects (the separate bit below them inverts)
`define CND_ZERO      2'h0
`define CND_CARRY     2'h1
`define CND_OVF       2'h2
// Register-file locations
`define ADDR_TIMER0   8'h56
`define ADDR_PORT_LO  8'h80
`define ADDR_PORT_HI  8'h88
// Reset values
`define FLAGS_RST     5'h00
`define WORKING_REGISTER_RST      8'h00
`define BSR_RST       4'h0
`define TO_RST        1'b1
`define PD_RST        1'b1
`define IRQ_EN_RST    1'b0
`endif

// ---- hdl/cbd_pkg.sv ----
// Types shared by the instruction decoder
package cbd_pkg;
   typedef struct packed {logic n; logic ov; logic z; logic dc; logic c;} cbd_flags_t;
   typedef struct packed {
      logic [3:0] op; logic [2:0] bit_idx; logic access; logic [7:0] file;
   } cbd_bit_fmt_t;
   typedef struct packed {
      logic [3:0] op; logic rel; logic [1:0] flag; logic inv; logic [7:0] off;
   } cbd_br_fmt_t;
   typedef struct packed {logic [3:0] op; logic link; logic [10:0] off;} cbd_rel_fmt_t;
   typedef struct packed {logic [7:0] op; logic [7:0] k;} cbd_lit_fmt_t;
   typedef struct packed {logic [3:0] op; logic [11:0] k;} cbd_ext_fmt_t;
   typedef struct packed {
      logic we; logic access; logic [7:0] addr; logic [7:0] wdata;
   } cbd_file_req_t;
   typedef struct packed {
      logic jump_abs; logic jump_rel; logic call; logic ret; logic shadow;
      logic push; logic pop; logic [19:0] target; logic [10:0] offset;
   } cbd_flow_t;
   typedef struct packed {logic we; logic [1:0] sel; logic [11:0] value;} cbd_ptr_load_t;
   typedef struct packed {logic rd; logic wr; logic [1:0] mode;} cbd_tbl_t;
   typedef struct packed {logic sleep; logic wdt_clr; logic sw_reset; logic presc_clr;} cbd_sys_t;
   typedef enum logic [1:0] {ST_RUN, ST_FLUSH, ST_WORD2} cbd_state_t;
   typedef enum logic [1:0] {W2_CALL, W2_ABSOLUTE_JUMP_OP, W2_POINTER_LOAD_OP} cbd_w2_kind_t;
endpackage

// ---- hdl/cbd_decoder.sv ----
// Instruction decoder and sequencer for bit, control, literal and table words
// Notes on behaviour
// - Bit test words skip the next word when the chosen bit is clear/set.
// - Conditional branches test one flag; one cycle, two when taken.
// - Absolute call uses two words, twenty address bits and a shadow flag.
// - Absolute jump uses two words giving twenty address bits.
// - Standby entry and watchdog clear update timeout and powerdown flags.
// - A stray second word beginning 1111 executes as a no-operation.
// - Stack pop and push act on the stack top, no flags changed.
// - Returns take two cycles; interrupt return sets both interrupt enables.
// - Literal return loads the working register and returns in two cycles.
// - Literal add updates carry, digit carry, zero, overflow, negative.
// - Literal and, or, xor update only zero and negative.
// - Literal minus working register updates all five arithmetic flags.
// - Literal multiply and literal load leave every flag unchanged.
// - Bank select load writes a 4-bit literal to the bank select register.
// - Pointer load takes two words to form a 12-bit pointer value.
// - Table reads with four pointer modes take two cycles.
// - Table writes with four pointer modes take two cycles.
// - Program counter changes other than absolute jump and call, and true tests, add a no-operation cycle.
// - Read-modify-write of a port register takes pin levels as source.
// - Writing the timer-zero count clears an assigned prescaler.
`timescale 1ns/100ps
`default_nettype none
`include "cbd_cfg.svh"
module cbd_decoder
   import cbd_pkg::*;
(
   input  wire logic          MCLK_I,
   input  wire logic          RST_B_I,
   input  wire logic [15:0]   INSTR_I,
   input  wire logic          INSTR_VALID_I,
   input  wire logic [7:0]    FILE_RDATA_I,
   input  wire logic [7:0]    PORT_PIN_I,
   input  wire logic          PRESCALE_ASSIGNED_I,
   output var  cbd_flow_t     FLOW_O,
   output var  cbd_file_req_t FILE_O,
   output var  cbd_ptr_load_t PTR_LOAD_O,
   output var  cbd_tbl_t      TBL_O,
   output var  cbd_sys_t      SYS_O,
   output var  cbd_flags_t    STATUS_O,
   output logic [7:0]         WORKING_REGISTER_O,
   output logic [3:0]         BSR_O,
   output logic [15:0]        PROD_O,
   output logic               TIMEOUT_O,
   output logic               POWERDOWN_O,
   output logic               GIE_O,
   output logic               PEIE_O,
   output logic               BUSY_O
);

   cbd_state_t    state;
   cbd_state_t    next_state;
   cbd_w2_kind_t  w2_kind;
   cbd_w2_kind_t  next_w2_kind;
   logic [7:0]    w1_k;
   logic [7:0]    next_w1_k;
   logic          w1_flag;
   logic          next_w1_flag;
   logic [1:0]    w1_sel;
   logic [1:0]    next_w1_sel;
   logic [7:0]    pin_meta;
   logic [7:0]    pin_sync;
   cbd_flow_t     next_flow;
   cbd_file_req_t next_file;
   cbd_ptr_load_t next_ptr;
   cbd_tbl_t      next_tbl;
   cbd_sys_t      next_sys;
   cbd_flags_t    next_status;
   logic [7:0]    next_working_register;
   logic [3:0]    next_bsr;
   logic [15:0]   next_prod;
   logic          next_timeout;
   logic          next_powerdown;
   logic          next_gie;
   logic          next_peie;

   // Views of the incoming word in each format
   cbd_bit_fmt_t  bit_w;
   cbd_br_fmt_t   br_w;
   cbd_rel_fmt_t  rel_w;
   cbd_lit_fmt_t  lit_w;
   cbd_ext_fmt_t  ext_w;
   logic          take;
   logic          is_port;
   logic          is_timer_zero_count;
   logic [7:0]    bit_mask;
   logic [7:0]    rmw_src;
   logic          file_bit;
   logic          cond_true;
   logic [8:0]    add_sum;
   logic [8:0]    sub_sum;
   logic [4:0]    add_nib;
   logic [4:0]    sub_nib;

   assign bit_w = cbd_bit_fmt_t'(INSTR_I);
   assign br_w  = cbd_br_fmt_t'(INSTR_I);
   assign rel_w = cbd_rel_fmt_t'(INSTR_I);
   assign lit_w = cbd_lit_fmt_t'(INSTR_I);
   assign ext_w = cbd_ext_fmt_t'(INSTR_I);
   assign take  = INSTR_VALID_I;

   // File operand classification and source selection
   assign is_port  = !bit_w.access && (bit_w.file >= `ADDR_PORT_LO)
                     && (bit_w.file <= `ADDR_PORT_HI);
   assign is_timer_zero_count  = !bit_w.access && (bit_w.file == `ADDR_TIMER0);
   assign bit_mask = 8'h01 << bit_w.bit_idx;
   assign rmw_src  = is_port ? pin_sync : FILE_RDATA_I;
   assign file_bit = |(FILE_RDATA_I & bit_mask);

   // Branch condition from the held flags
   always_comb begin
      case (br_w.flag)
         `CND_ZERO:  cond_true = STATUS_O.z ^ br_w.inv;
         `CND_CARRY: cond_true = STATUS_O.c ^ br_w.inv;
         `CND_OVF:   cond_true = STATUS_O.ov ^ br_w.inv;
         default:    cond_true = STATUS_O.n ^ br_w.inv;
      endcase
   end

   // Literal adder and subtractor
   assign add_sum = {1'b0, WORKING_REGISTER_O} + {1'b0, lit_w.k};
   assign sub_sum = {1'b0, lit_w.k} + {1'b0, ~WORKING_REGISTER_O} + 9'h001;
   assign add_nib = {1'b0, WORKING_REGISTER_O[3:0]} + {1'b0, lit_w.k[3:0]};
   assign sub_nib = {1'b0, lit_w.k[3:0]} + {1'b0, ~WORKING_REGISTER_O[3:0]} + 5'h01;

   // Pin levels pass two flops before use
   always_ff @(posedge MCLK_I) begin
      pin_meta <= PORT_PIN_I;
      pin_sync <= pin_meta;
   end

   // Decode and sequencing: next values
   always_comb begin
      next_state     = state;
      next_w2_kind   = w2_kind;
      next_w1_k      = w1_k;
      next_w1_flag   = w1_flag;
      next_w1_sel    = w1_sel;
      next_flow      = '0;
      next_file      = '0;
      next_ptr       = '0;
      next_tbl       = '0;
      next_sys       = '0;
      next_status    = STATUS_O;
      next_working_register      = WORKING_REGISTER_O;
      next_bsr       = BSR_O;
      next_prod      = PROD_O;
      next_timeout   = TIMEOUT_O;
      next_powerdown = POWERDOWN_O;
      next_gie       = GIE_O;
      next_peie      = PEIE_O;
      if (take) begin
         case (state)
            ST_FLUSH: begin
               next_state = ST_RUN;
            end
            ST_WORD2: begin
               next_state = ST_RUN;
               case (w2_kind)
                  W2_POINTER_LOAD_OP: begin
                     next_ptr.we    = 1'b1;
                     next_ptr.sel   = w1_sel;
                     next_ptr.value = {w1_k[3:0], lit_w.k};
                  end
                  W2_CALL: begin
                     next_flow.jump_abs = 1'b1;
                     next_flow.call     = 1'b1;
                     next_flow.push     = 1'b1;
                     next_flow.shadow   = w1_flag;
                     next_flow.target   = {ext_w.k, w1_k};
                  end
                  default: begin
                     next_flow.jump_abs = 1'b1;
                     next_flow.target   = {ext_w.k, w1_k};
                  end
               endcase
            end
            default: begin
               case (bit_w.op)
                  `OPN_SKIP_CLR, `OPN_SKIP_SET: begin
                     if (file_bit == (bit_w.op == `OPN_SKIP_SET))
                        next_state = ST_FLUSH;
                  end
                  `OPN_BIT_CLR, `OPN_BIT_SET, `OPN_BIT_TGL: begin
                     next_file.we     = 1'b1;
                     next_file.access = bit_w.access;
                     next_file.addr   = bit_w.file;
                     if (bit_w.op == `OPN_BIT_CLR)
                        next_file.wdata = rmw_src & ~bit_mask;
                     else if (bit_w.op == `OPN_BIT_SET)
                        next_file.wdata = rmw_src | bit_mask;
                     else
                        next_file.wdata = rmw_src ^ bit_mask;
                     next_sys.presc_clr = is_timer_zero_count && PRESCALE_ASSIGNED_I;
                  end
                  `OPN_REL: begin
                     next_flow.jump_rel = 1'b1;
                     next_flow.offset   = rel_w.off;
                     next_flow.call     = rel_w.link;
                     next_flow.push     = rel_w.link;
                     next_state         = ST_FLUSH;
                  end
                  `OPN_CTRL: begin
                     if (!br_w.rel) begin
                        if (cond_true) begin
                           next_flow.jump_rel = 1'b1;
                           next_flow.offset   = {{3{br_w.off[7]}}, br_w.off};
                           next_state         = ST_FLUSH;
                        end
                     end else if (INSTR_I[15:9] == `OP7_CALL) begin
                        next_w2_kind = W2_CALL;
                        next_w1_k    = lit_w.k;
                        next_w1_flag = INSTR_I[8];
                        next_state   = ST_WORD2;
                     end else if (lit_w.op == `OPB_ABSOLUTE_JUMP_OP) begin
                        next_w2_kind = W2_ABSOLUTE_JUMP_OP;
                        next_w1_k    = lit_w.k;
                        next_state   = ST_WORD2;
                     end else if (lit_w.op == `OPB_POINTER_LOAD_OP && INSTR_I[7:6] == `POINTER_LOAD_OP_PAD) begin
                        next_w2_kind = W2_POINTER_LOAD_OP;
                        next_w1_k    = lit_w.k;
                        next_w1_sel  = INSTR_I[5:4];
                        next_state   = ST_WORD2;
                     end
                  end
                  `OPN_EXT: begin
                     next_state = ST_RUN;
                  end
                  default: begin
                     case (lit_w.op)
                        `OPB_LIT_ADD: begin
                           next_working_register      = add_sum[7:0];
                           next_status.c  = add_sum[8];
                           next_status.dc = add_nib[4];
                           next_status.z  = (add_sum[7:0] == 8'h00);
                           next_status.n  = add_sum[7];
                           next_status.ov = (WORKING_REGISTER_O[7] == lit_w.k[7])
                                            && (add_sum[7] != WORKING_REGISTER_O[7]);
                        end
                        `OPB_LIT_SUB: begin
                           next_working_register      = sub_sum[7:0];
                           next_status.c  = sub_sum[8];
                           next_status.dc = sub_nib[4];
                           next_status.z  = (sub_sum[7:0] == 8'h00);
                           next_status.n  = sub_sum[7];
                           next_status.ov = (WORKING_REGISTER_O[7] != lit_w.k[7])
                                            && (sub_sum[7] != lit_w.k[7]);
                        end
                        `OPB_LIT_AND, `OPB_LIT_OR, `OPB_LIT_XOR: begin
                           if (lit_w.op == `OPB_LIT_AND)
                              next_working_register = WORKING_REGISTER_O & lit_w.k;
                           else if (lit_w.op == `OPB_LIT_OR)
                              next_working_register = WORKING_REGISTER_O | lit_w.k;
                           else
                              next_working_register = WORKING_REGISTER_O ^ lit_w.k;
                           next_status.z = (next_working_register == 8'h00);
                           next_status.n = next_working_register[7];
                        end
                        `OPB_LIT_MUL: next_prod = WORKING_REGISTER_O * lit_w.k;
                        `OPB_LIT_MOV: next_working_register = lit_w.k;
                        `OPB_LIT_RET: begin
                           next_working_register      = lit_w.k;
                           next_flow.ret  = 1'b1;
                           next_flow.pop  = 1'b1;
                           next_state     = ST_FLUSH;
                        end
                        default: begin
                           if (INSTR_I[15:4] == `OP12_BANK_SELECT_LOAD_OP)
                              next_bsr = INSTR_I[3:0];
                           else if (INSTR_I[15:1] == `OP15_INTERRUPT_RETURN_OP
                                    || INSTR_I[15:1] == `OP15_RETURN) begin
                              next_flow.ret    = 1'b1;
                              next_flow.pop    = 1'b1;
                              next_flow.shadow = INSTR_I[0];
                              next_state       = ST_FLUSH;
                              if (INSTR_I[15:1] == `OP15_INTERRUPT_RETURN_OP) begin
                                 next_gie  = 1'b1;
                                 next_peie = 1'b1;
                              end
                           end else if (INSTR_I[15:3] == `OP13_TABLE) begin
                              next_tbl.rd   = !INSTR_I[2];
                              next_tbl.wr   = INSTR_I[2];
                              next_tbl.mode = INSTR_I[1:0];
                              next_state    = ST_FLUSH;
                           end else if (INSTR_I == `WORD_SLEEP) begin
                              next_sys.sleep = 1'b1;
                              next_timeout   = 1'b1;
                              next_powerdown = 1'b0;
                           end else if (INSTR_I == `WORD_WATCHDOG_CLEAR_OP) begin
                              next_sys.wdt_clr = 1'b1;
                              next_timeout     = 1'b1;
                              next_powerdown   = 1'b1;
                           end else if (INSTR_I == `WORD_PUSH)
                              next_flow.push = 1'b1;
                           else if (INSTR_I == `WORD_POP)
                              next_flow.pop = 1'b1;
                           else if (INSTR_I == `WORD_RESET) begin
                              next_sys.sw_reset = 1'b1;
                              next_status       = `FLAGS_RST;
                              next_working_register         = `WORKING_REGISTER_RST;
                              next_bsr          = `BSR_RST;
                              next_timeout      = `TO_RST;
                              next_powerdown    = `PD_RST;
                              next_gie          = `IRQ_EN_RST;
                              next_peie         = `IRQ_EN_RST;
                           end
                        end
                     endcase
                  end
               endcase
            end
         endcase
      end
   end

   // Decode and sequencing: registers
   always_ff @(posedge MCLK_I) begin
      if (!RST_B_I) begin
         state       <= ST_RUN;
         w2_kind     <= W2_ABSOLUTE_JUMP_OP;
         w1_k        <= 8'h00;
         w1_flag     <= 1'b0;
         w1_sel      <= 2'h0;
         FLOW_O      <= '0;
         FILE_O      <= '0;
         PTR_LOAD_O  <= '0;
         TBL_O       <= '0;
         SYS_O       <= '0;
         STATUS_O    <= `FLAGS_RST;
         WORKING_REGISTER_O      <= `WORKING_REGISTER_RST;
         BSR_O       <= `BSR_RST;
         PROD_O      <= 16'h0000;
         TIMEOUT_O   <= `TO_RST;
         POWERDOWN_O <= `PD_RST;
         GIE_O       <= `IRQ_EN_RST;
         PEIE_O      <= `IRQ_EN_RST;
         BUSY_O      <= 1'b0;
      end else begin
         state       <= next_state;
         w2_kind     <= next_w2_kind;
         w1_k        <= next_w1_k;
         w1_flag     <= next_w1_flag;
         w1_sel      <= next_w1_sel;
         FLOW_O      <= next_flow;
         FILE_O      <= next_file;
         PTR_LOAD_O  <= next_ptr;
         TBL_O       <= next_tbl;
         SYS_O       <= next_sys;
         STATUS_O    <= next_status;
         WORKING_REGISTER_O      <= next_working_register;
         BSR_O       <= next_bsr;
         PROD_O      <= next_prod;
         TIMEOUT_O   <= next_timeout;
         POWERDOWN_O <= next_powerdown;
         GIE_O       <= next_gie;
         PEIE_O      <= next_peie;
         BUSY_O      <= (next_state != ST_RUN);
      end
   end

   // Checks on the decoded behaviour
   default clocking cb @(posedge MCLK_I); endclocking
   default disable iff (!RST_B_I);

   logic run_take;
   assign run_take = take && (state == ST_RUN);

   skip_clear_a: assert property (run_take && bit_w.op == `OPN_SKIP_CLR && !file_bit
      |=> state == ST_FLUSH ##0 BUSY_O) else $error("skip on clear bit not taken");
   bit_set_a: assert property (run_take && bit_w.op == `OPN_BIT_SET
      |=> FILE_O.we && STATUS_O == $past(STATUS_O)) else $error("bit set write wrong");
   branch_taken_a: assert property (run_take && bit_w.op == `OPN_CTRL && !br_w.rel && cond_true
      |=> FLOW_O.jump_rel && state == ST_FLUSH) else $error("taken branch not two cycles");
   branch_fall_a: assert property (run_take && bit_w.op == `OPN_CTRL && !br_w.rel && !cond_true
      |=> !FLOW_O.jump_rel && state == ST_RUN) else $error("untaken branch misbehaved");
   absolute_jump_op_words_a: assert property (run_take && lit_w.op == `OPB_ABSOLUTE_JUMP_OP ##1 take
      |=> FLOW_O.jump_abs && FLOW_O.target[7:0] == $past(w1_k)) else $error("jump target wrong");
   sleep_flags_a: assert property (run_take && INSTR_I == `WORD_SLEEP
      |=> TIMEOUT_O && !POWERDOWN_O && SYS_O.sleep) else $error("standby flags wrong");
   stray_ext_a: assert property (run_take && bit_w.op == `OPN_EXT
      |=> !FILE_O.we && FLOW_O == '0 && $stable(WORKING_REGISTER_O)) else $error("stray word not idle");
   irq_return_a: assert property (run_take && INSTR_I[15:1] == `OP15_INTERRUPT_RETURN_OP
      |=> GIE_O && PEIE_O && FLOW_O.ret && BUSY_O) else $error("interrupt return wrong");
   lit_add_a: assert property (run_take && lit_w.op == `OPB_LIT_ADD
      |=> WORKING_REGISTER_O == 8'($past(WORKING_REGISTER_O) + $past(lit_w.k))) else $error("literal add wrong");
   logic_flags_a: assert property (run_take && lit_w.op == `OPB_LIT_AND
      |=> STATUS_O.c == $past(STATUS_O.c) && STATUS_O.z == (WORKING_REGISTER_O == 8'h00))
      else $error("logic flags wrong");
   bank_load_a: assert property (run_take && INSTR_I[15:4] == `OP12_BANK_SELECT_LOAD_OP
      |=> BSR_O == $past(INSTR_I[3:0])) else $error("bank select load wrong");
   presc_clr_a: assert property (run_take && bit_w.op == `OPN_BIT_SET && is_timer_zero_count && PRESCALE_ASSIGNED_I
      |=> SYS_O.presc_clr) else $error("prescaler not cleared");

   skip_seen_c: cover property (run_take && bit_w.op == `OPN_SKIP_SET ##1 state == ST_FLUSH);
   call_seen_c: cover property (FLOW_O.call && FLOW_O.jump_abs);
   table_seen_c: cover property (TBL_O.rd ##1 BUSY_O);
   lit_ret_c: cover property (run_take && lit_w.op == `OPB_LIT_RET);

endmodule
`default_nettype wire

// ---- bench/cbd_file_model.sv ----
// Register-file model answering the decoder's file reads and writes
`timescale 1ns/100ps
`default_nettype none
module cbd_file_model
   import cbd_pkg::*;
(
   input  wire logic          clk_i,
   input  wire logic [15:0]   instr_i,
   input  wire cbd_file_req_t file_i,
   output logic [7:0]         rdata_o
);
   logic [7:0] mem [256];
   // Each location starts holding its own address
   initial begin
      for (int i = 0; i < 256; i++) begin
         mem[i] = i[7:0];
      end
   end
   // Writes land on the clock, reads follow the word's address at once
   always @(posedge clk_i) begin
      if (file_i.we) begin
         mem[file_i.addr] <= file_i.wdata;
      end
   end
   assign rdata_o = mem[instr_i[7:0]];
endmodule
`default_nettype wire

// ---- bench/cbd_decoder_bench.sv ----
// Self-checking bench for the instruction decoder
`timescale 1ns/100ps
`default_nettype none
module cpu_bit_control_literal_decode_bench;
   import cbd_pkg::*;
   logic          mclk = 1'b0;
   logic          rst_b = 1'b0;
   logic [15:0]   instr = 16'h0000;
   logic          valid = 1'b0;
   logic [7:0]    pins = 8'hA5;
   logic          presc = 1'b1;
   logic [7:0]    rdata;
   cbd_flow_t     flow;
   cbd_file_req_t file;
   cbd_tbl_t      tbl;
   cbd_sys_t      sys;
   cbd_flags_t    stat;
   logic [7:0]    working_register;
   cbd_ptr_load_t ptr;
   logic [3:0]    bank_select_register;
   logic [15:0]   prod;
   logic          tmo, pdn, gie, peie, busy;
   int            err_count = 0;
   int            n_compared = 0;
   cbd_decoder cbd_decoder_i (.MCLK_I(mclk), .RST_B_I(rst_b), .INSTR_I(instr),
      .INSTR_VALID_I(valid), .FILE_RDATA_I(rdata), .PORT_PIN_I(pins),
      .PRESCALE_ASSIGNED_I(presc), .FLOW_O(flow), .FILE_O(file), .PTR_LOAD_O(ptr),
      .TBL_O(tbl), .SYS_O(sys), .STATUS_O(stat), .WORKING_REGISTER_O(working_register), .BSR_O(bank_select_register), .PROD_O(prod),
      .TIMEOUT_O(tmo), .POWERDOWN_O(pdn), .GIE_O(gie), .PEIE_O(peie), .BUSY_O(busy));
   cbd_file_model cbd_file_model_i (.clk_i(mclk), .instr_i(instr), .file_i(file),
      .rdata_o(rdata));
   // Clock and hang guard
   initial begin
      forever #4 mclk = ~mclk;
   end
   initial begin
      #8000;
      err_count++;
      final_report();
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_count++;
         $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask
   // One word is taken at one edge; results are visible just after it
   task automatic issue(input logic [15:0] w);
      @(posedge mclk);
      #1;
      instr = w;
      valid = 1'b1;
      @(posedge mclk);
      #1;
      valid = 1'b0;
   endtask
   task automatic t_literal();
      issue(16'h0E80);
      check({working_register, 3'h0, stat}, {8'h80, 8'h00});
      issue(16'h0F80);
      check({working_register, 3'h0, stat}, {8'h00, 8'h0D});
   endtask
   task automatic t_branch();
      issue(16'hE003);
      check({flow.jump_rel, flow.offset, busy}, {1'b1, 11'h003, 1'b1});
      issue(16'h0E11);
      check({working_register, busy}, {8'h00, 1'b0});
      issue(16'hEF12);
      check(busy, 1'b1);
      issue(16'hF345);
      check({flow.jump_abs, flow.target}, {1'b1, 20'h34512});
   endtask
   task automatic t_bits();
      issue(16'h8056);
      check({file.we, file.addr, file.wdata, sys.presc_clr}, {1'b1, 16'h5657, 1'b1});
      issue(16'hB656);
      check(busy, 1'b1);
      issue(16'h0E22);
      check({working_register, busy}, {8'h00, 1'b0});
   endtask
   task automatic t_system();
      issue(16'h0003);
      check({tmo, pdn}, 2'b10);
      issue(16'h0004);
      check({tmo, pdn}, 2'b11);
      issue(16'h0009);
      check({tbl.rd, tbl.mode, busy}, {1'b1, 2'h1, 1'b1});
      issue(16'h0000);
      issue(16'h0E5A);
      issue(16'h00FF);
      check({sys.sw_reset, working_register, tmo, pdn, gie, peie}, {1'b1, 8'h00, 4'hC});
   endtask
   // Literal, long-word, return, port and stack words not reached above
   task automatic t_misc();
      issue(16'h0E0F);
      issue(16'h0D10);
      check({prod, 3'h0, stat}, {16'h00F0, 8'h00});
      issue(16'h0B3C);
      check({working_register, 3'h0, stat}, {8'h0C, 8'h00});
      issue(16'h0A8C);
      check({working_register, 3'h0, stat}, {8'h80, 8'h10});
      issue(16'h0801);
      check({working_register, 3'h0, stat}, {8'h81, 8'h1A});
      issue(16'hE005);
      check({flow.jump_rel, busy}, 2'b00);
      issue(16'hF123);
      check({flow.jump_abs, flow.jump_rel, flow.call, busy, working_register}, {4'h0, 8'h81});
      issue(16'h0107);
      check(bank_select_register, 4'h7);
      issue(16'hEE2A);
      issue(16'hF0BC);
      check({ptr.we, ptr.sel, ptr.value}, {1'b1, 2'h2, 12'hABC});
      issue(16'hEC34);
      issue(16'hF567);
      check({flow.call, flow.push, flow.jump_abs, flow.target}, {3'h7, 20'h56734});
      issue(16'hD805);
      check({flow.jump_rel, flow.call, flow.push, flow.offset, busy}, {3'h7, 11'h005, 1'b1});
      issue(16'h0000);
      issue(16'h0011);
      check({gie, peie, flow.ret, flow.pop, flow.shadow, busy}, 6'h3F);
      issue(16'h0000);
      issue(16'h0C66);
      check({working_register, flow.ret, busy}, {8'h66, 2'b11});
      issue(16'h0000);
      issue(16'h7080);
      check({file.we, file.addr, file.wdata, sys.presc_clr}, {1'b1, 16'h80A4, 1'b0});
      issue(16'h0005);
      check({flow.push, flow.pop}, 2'b10);
      issue(16'h0006);
      check({flow.push, flow.pop}, 2'b01);
      issue(16'h000F);
      check({tbl.wr, tbl.mode, busy}, 4'hF);
      issue(16'h0000);
   endtask
   task automatic final_report();
      $display("Compared %0d, errors %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // Main sequence
   initial begin
      repeat (4) @(posedge mclk);
      #1;
      rst_b = 1'b1;
      check({tmo, pdn, gie, peie, busy}, 5'h18);
      t_literal();
      t_branch();
      t_bits();
      t_system();
      t_misc();
      final_report();
   end
endmodule
`default_nettype wire
